// ### logic/rxf_port_regs.sv
`timescale 1ns/1ps
module rxf_port_regs import rxf_pkg::*; #(
	parameter int unsigned RAI_INTEG_CYCLES = RAI_INTEG_CYCLES_DEF
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// register access
	input wire logic wr_en,
	input wire logic [8:0] index,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata,
	output logic hit,
	// framer side
	input wire logic frame_tick,
	input wire logic freeze_request,
	input wire logic e1_mode,
	input wire logic rai_raw,
	input wire logic [7:0] monitor_data,
	output rxf_port_cfg_t cfg
);

	localparam int unsigned CW = $clog2(RAI_INTEG_CYCLES + 1);

	typedef struct packed {
		logic [7:0] hdlc_ctrl;
		logic [7:0] suppress;
		logic [7:0] mon_sel;
		logic [7:0] sig_ctrl;
		logic [7:0] t1_ctrl2;
		rxf_hdlc_state_t fsm;
		logic [1:0] frames;
		logic [4:0] active_sel;
		logic rai_status;
		logic [CW-1:0] rai_cnt;
		rxf_port_cfg_t cfg;
	} rxf_port_state_t;

	rxf_port_state_t s;
	rxf_port_state_t next_s;

	// =====================================================================
	// next state
	always_comb begin
		next_s = s;
		case (s.fsm)
			RXF_HDLC_IDLE: begin
			end
			RXF_HDLC_FLUSH: begin
				if (frame_tick) begin
					if (s.frames == HDLC_RESET_FRAMES - 2'h1) begin
						next_s.fsm = RXF_HDLC_IDLE; // [RULE2]
						next_s.active_sel = s.hdlc_ctrl[HC_SEL_LSB +: 5]; // [RULE5]
					end else begin
						next_s.frames = s.frames + 2'h1;
					end
				end
			end
			default: begin
				next_s.fsm = RXF_HDLC_IDLE;
			end
		endcase
		if (wr_en) begin
			case (index)
				IDX_HDLC_CONTROL: begin
					next_s.hdlc_ctrl = wdata & MASK_HDLC_CONTROL; // [RULE20]
					// a new request restarts the flush; writing zero cannot abort it
					if (wdata[HC_RESET_BIT]) begin
						next_s.fsm = RXF_HDLC_FLUSH; // [RULE2]
						next_s.frames = 2'h0;
					end
				end
				IDX_BIT_SUPPRESS: begin
					next_s.suppress = wdata & MASK_BIT_SUPPRESS;
				end
				IDX_MONITOR_SELECT: begin
					next_s.mon_sel = wdata & MASK_MONITOR_SELECT; // [RULE20]
				end
				IDX_SIG_CONTROL: begin
					next_s.sig_ctrl = wdata & MASK_SIG_CONTROL; // [RULE20]
				end
				IDX_T1_CONTROL_TWO: begin
					next_s.t1_ctrl2 = wdata & MASK_T1_CONTROL_TWO; // [RULE20]
				end
				default: begin
				end
			endcase
		end
		// alarm integrator: needs the change to persist past the window
		if (!s.t1_ctrl2[T2_RAI_INTEG_BIT]) begin
			next_s.rai_status = rai_raw; // [RULE18]
			next_s.rai_cnt = '0;
		end else if (rai_raw != s.rai_status) begin
			if (s.rai_cnt == CW'(RAI_INTEG_CYCLES)) begin
				next_s.rai_status = rai_raw; // [RULE18]
				next_s.rai_cnt = '0;
			end else begin
				next_s.rai_cnt = s.rai_cnt + CW'(1);
			end
		end else begin
			next_s.rai_cnt = '0;
		end
		next_s.cfg.crc_display = next_s.hdlc_ctrl[HC_CRC_BIT]; // [RULE1]
		next_s.cfg.hdlc_reset_busy = (next_s.fsm == RXF_HDLC_FLUSH); // [RULE2]
		next_s.cfg.map_select = next_s.hdlc_ctrl[HC_MAP_BIT]; // [RULE3]
		next_s.cfg.channel_active = next_s.active_sel; // [RULE4]
		next_s.cfg.bit_suppress = next_s.suppress; // [RULE6]
		next_s.cfg.monitor_channel = next_s.mon_sel[4:0]; // [RULE7]
		next_s.cfg.force_sig_ones = !e1_mode && next_s.sig_ctrl[SC_ONES_CAS_BIT]; // [RULE8]
		next_s.cfg.cas_resync_mode = e1_mode // [RULE9] [RULE10]
			&& next_s.sig_ctrl[SC_ONES_CAS_BIT]; // [RULE11]
		// force overrides the enable-gated request
		next_s.cfg.sig_freeze = next_s.sig_ctrl[SC_FORCE_FREEZE_BIT] // [RULE12]
			|| (next_s.sig_ctrl[SC_FREEZE_EN_BIT] && freeze_request); // [RULE13]
		next_s.cfg.sig_stable_multiframes = next_s.sig_ctrl[SC_INTEG_BIT] ?
			SIG_INTEG_MULTIFRAMES : SIG_IMMEDIATE; // [RULE14]
		next_s.cfg.subscriber_sync_enable = next_s.t1_ctrl2[T2_SLC_BIT]; // [RULE15]
		case (next_s.t1_ctrl2[T2_OOF_LSB +: 2])
			2'h0: next_s.cfg.oof_window = OOF_WIN_4; // [RULE17]
			2'h1: next_s.cfg.oof_window = OOF_WIN_5; // [RULE17]
			default: next_s.cfg.oof_window = OOF_WIN_6; // [RULE17]
		endcase
		next_s.cfg.remote_alarm_integrate = next_s.t1_ctrl2[T2_RAI_INTEG_BIT]; // [RULE18]
		next_s.cfg.superframe_alarm_select = next_s.t1_ctrl2[T2_D4_SEL_BIT]; // [RULE19]
		next_s.cfg.remote_alarm = next_s.rai_status; // [RULE18]
	end

	// =====================================================================
	// registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '{hdlc_ctrl: RST_HDLC_CONTROL, suppress: RST_BIT_SUPPRESS,
				mon_sel: RST_MONITOR_SELECT, sig_ctrl: RST_SIG_CONTROL,
				t1_ctrl2: RST_T1_CONTROL_TWO, fsm: RXF_HDLC_IDLE, frames: 2'h0,
				active_sel: 5'h00, rai_status: 1'b0, rai_cnt: '0,
				cfg: '{oof_window: OOF_WIN_4, sig_stable_multiframes: SIG_IMMEDIATE,
				default: '0}};
		end else begin
			s <= next_s;
		end
	end

	// =====================================================================
	// read side
	always_comb begin
		rdata = 8'h00;
		hit = 1'b1;
		case (index)
			IDX_HDLC_CONTROL: begin
				rdata = s.hdlc_ctrl;
				rdata[HC_RESET_BIT] = (s.fsm == RXF_HDLC_FLUSH); // [RULE2]
			end
			IDX_BIT_SUPPRESS: rdata = s.suppress;
			IDX_MONITOR_SELECT: rdata = s.mon_sel;
			IDX_SIG_CONTROL: rdata = s.sig_ctrl;
			IDX_T1_CONTROL_TWO: rdata = s.t1_ctrl2;
			IDX_MONITOR_DATA: rdata = monitor_data; // [RULE7]
			IDX_PORT_STATUS: begin
				rdata[ST_SEL_LSB +: 5] = s.active_sel;
				rdata[ST_RAI_BIT] = s.rai_status;
				rdata[ST_BUSY_BIT] = (s.fsm == RXF_HDLC_FLUSH);
			end
			default: hit = 1'b0;
		endcase
	end

	assign cfg = s.cfg;

endmodule // rxf_port_regs

// ### logic/rxf_pkg.sv
package rxf_pkg;

	// =====================================================================
	// geometry
	localparam int unsigned NUM_PORTS = 4;
	localparam int unsigned ADDR_W_MIN = 13;
	localparam int unsigned PORT_SHIFT = 9;
	localparam int unsigned PORT_STRIDE_IDX = 32'h200;

	// =====================================================================
	// register indexes (byte address is four times the index)
	localparam logic [8:0] IDX_HDLC_CONTROL = 9'h010;
	localparam logic [8:0] IDX_BIT_SUPPRESS = 9'h011;
	localparam logic [8:0] IDX_MONITOR_SELECT = 9'h012;
	localparam logic [8:0] IDX_SIG_CONTROL = 9'h013;
	localparam logic [8:0] IDX_T1_CONTROL_TWO = 9'h014;
	localparam logic [8:0] IDX_MONITOR_DATA = 9'h0F0;
	localparam logic [8:0] IDX_PORT_STATUS = 9'h0F1;

	// =====================================================================
	// field positions
	localparam int unsigned HC_CRC_BIT = 7;
	localparam int unsigned HC_RESET_BIT = 6;
	localparam int unsigned HC_MAP_BIT = 5;
	localparam int unsigned HC_SEL_LSB = 0;
	localparam int unsigned SC_ONES_CAS_BIT = 4;
	localparam int unsigned SC_FORCE_FREEZE_BIT = 2;
	localparam int unsigned SC_FREEZE_EN_BIT = 1;
	localparam int unsigned SC_INTEG_BIT = 0;
	localparam int unsigned T2_SLC_BIT = 4;
	localparam int unsigned T2_OOF_LSB = 2;
	localparam int unsigned T2_RAI_INTEG_BIT = 1;
	localparam int unsigned T2_D4_SEL_BIT = 0;
	localparam int unsigned ST_SEL_LSB = 0;
	localparam int unsigned ST_RAI_BIT = 5;
	localparam int unsigned ST_BUSY_BIT = 6;

	// =====================================================================
	// writable bits and reset values
	localparam logic [7:0] MASK_HDLC_CONTROL = 8'hBF;
	localparam logic [7:0] MASK_BIT_SUPPRESS = 8'hFF;
	localparam logic [7:0] MASK_MONITOR_SELECT = 8'h1F;
	localparam logic [7:0] MASK_SIG_CONTROL = 8'h17;
	localparam logic [7:0] MASK_T1_CONTROL_TWO = 8'h1F;
	localparam logic [7:0] RST_HDLC_CONTROL = 8'h00;
	localparam logic [7:0] RST_BIT_SUPPRESS = 8'h00;
	localparam logic [7:0] RST_MONITOR_SELECT = 8'h00;
	localparam logic [7:0] RST_SIG_CONTROL = 8'h00;
	localparam logic [7:0] RST_T1_CONTROL_TWO = 8'h00;

	// =====================================================================
	// timing
	localparam logic [1:0] HDLC_RESET_FRAMES = 2'h2;
	localparam logic [1:0] SIG_INTEG_MULTIFRAMES = 2'h3;
	localparam logic [1:0] SIG_IMMEDIATE = 2'h1;
	localparam logic [2:0] OOF_WIN_4 = 3'h4;
	localparam logic [2:0] OOF_WIN_5 = 3'h5;
	localparam logic [2:0] OOF_WIN_6 = 3'h6;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned RAI_INTEG_MS = 200;
	localparam int unsigned RAI_INTEG_CYCLES_DEF = RAI_INTEG_MS * 1000000 / CLK_PERIOD_NS;

	// =====================================================================
	// per-port control handed to the framer datapath
	typedef struct packed {
		logic crc_display;
		logic hdlc_reset_busy;
		logic map_select;
		logic [4:0] channel_active;
		logic [7:0] bit_suppress;
		logic [4:0] monitor_channel;
		logic force_sig_ones;
		logic cas_resync_mode;
		logic sig_freeze;
		logic [1:0] sig_stable_multiframes;
		logic subscriber_sync_enable;
		logic [2:0] oof_window;
		logic remote_alarm_integrate;
		logic superframe_alarm_select;
		logic remote_alarm;
	} rxf_port_cfg_t;

	typedef enum logic [1:0] {
		RXF_HDLC_IDLE = 2'b01,
		RXF_HDLC_FLUSH = 2'b10
	} rxf_hdlc_state_t;

endpackage

// ### logic/rxf_ctrl_regs.sv
`timescale 1ns/1ps
// Operation
// [RULE1] crc display bit appends check code
// [RULE2] hdlc reset self-clears within two frames
// [RULE3] map select picks channels or link bits
// [RULE4] five-bit field picks hdlc channel
// [RULE5] new channel applies only after reset
// [RULE6] suppress bits drop channel bits
// [RULE7] monitor field picks presented channel data
// [RULE8] t1 bit four forces signaling ones
// [RULE9] e1 resync on two bad alignments
// [RULE10] cas mode adds all-zero slot resync
// [RULE11] alternate criterion needs a one first
// [RULE12] force freeze overrides freeze enable
// [RULE13] freeze only while enable set
// [RULE14] integration needs three stable multiframes
// [RULE15] bit four enables subscriber synchronizer
// [RULE16] bank repeats per port, stride 200h
// [RULE17] out-of-frame field sets threshold
// [RULE18] remote alarm integration over 200ms
// [RULE19] superframe alarm select picks alarm type
// [RULE20] unused bits read zero, ignore writes
module rxf_ctrl_regs import rxf_pkg::*; #(
	parameter int unsigned NPORTS = NUM_PORTS,
	parameter int unsigned ADDR_W = ADDR_W_MIN,
	parameter int unsigned RAI_INTEG_CYCLES = RAI_INTEG_CYCLES_DEF
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// framer side, per port
	input wire logic [NPORTS-1:0] frame_tick,
	input wire logic [NPORTS-1:0] freeze_request,
	input wire logic [NPORTS-1:0] e1_mode,
	input wire logic [NPORTS-1:0] rai_raw,
	input wire logic [NPORTS-1:0][7:0] monitor_data,
	output rxf_port_cfg_t [NPORTS-1:0] port_cfg
);

	// =====================================================================
	// elaboration checks
	if (NPORTS < 1 || NPORTS > 4) begin : g_bad_ports
		$error("NPORTS must be 1 to 4");
	end
	if (ADDR_W < ADDR_W_MIN) begin : g_bad_addr
		$error("ADDR_W too small for the port stride");
	end
	if (RAI_INTEG_CYCLES < 1) begin : g_bad_rai
		$error("RAI_INTEG_CYCLES must be at least one");
	end

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} rxf_apb_state_t;

	rxf_apb_state_t s;
	rxf_apb_state_t next_s;

	// =====================================================================
	// address decode
	logic [ADDR_W-3:0] word_idx;
	logic [8:0] local_idx;
	logic [1:0] port_sel;
	logic high_zero;
	logic port_ok;
	logic [NPORTS-1:0][7:0] port_rdata;
	logic [NPORTS-1:0] port_hit;
	logic [NPORTS-1:0] port_wr;
	logic commit;

	assign word_idx = paddr[ADDR_W-1:2];
	assign local_idx = word_idx[8:0];
	assign port_sel = word_idx[PORT_SHIFT +: 2]; // [RULE16]
	assign high_zero = (paddr >> (PORT_SHIFT + 4)) == '0;
	assign port_ok = high_zero && (32'(port_sel) < NPORTS);
	// write lands only at the access edge, and only if decode accepted it
	assign commit = psel && penable && s.pready && pwrite && !s.pslverr;

	// =====================================================================
	// one bank per port
	for (genvar p = 0; p < NPORTS; p++) begin : g_port
		assign port_wr[p] = commit && (32'(port_sel) == p); // [RULE16]
		rxf_port_regs #(
			.RAI_INTEG_CYCLES(RAI_INTEG_CYCLES)
		) u_port (
			.pclk(pclk),
			.presetn(presetn),
			.wr_en(port_wr[p]),
			.index(local_idx),
			.wdata(pwdata[7:0]),
			.rdata(port_rdata[p]),
			.hit(port_hit[p]),
			.frame_tick(frame_tick[p]),
			.freeze_request(freeze_request[p]),
			.e1_mode(e1_mode[p]),
			.rai_raw(rai_raw[p]),
			.monitor_data(monitor_data[p]),
			.cfg(port_cfg[p])
		);
	end

	// =====================================================================
	// apb: no wait state, answer decided in the setup cycle
	always_comb begin
		next_s = s;
		next_s.pready = 1'b0;
		if (psel && !penable) begin
			next_s.pready = 1'b1;
			next_s.prdata = 32'h0000_0000;
			next_s.pslverr = 1'b1;
			if (port_ok && port_hit[port_sel[$clog2(NPORTS > 1 ? NPORTS : 2)-1:0]]) begin
				next_s.pslverr = 1'b0;
				if (!pwrite) begin
					next_s.prdata = {24'h00_0000,
						port_rdata[port_sel[$clog2(NPORTS > 1 ? NPORTS : 2)-1:0]]}; // [RULE20]
				end
			end
		end else if (psel && penable && s.pready) begin
			next_s.pslverr = 1'b0;
			next_s.prdata = 32'h0000_0000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '{prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;

endmodule // rxf_ctrl_regs

// ### verif/rxf_ctrl_regs_properties.sv
`timescale 1ns/1ps
module rxf_ctrl_regs_properties import rxf_pkg::*; #(
	parameter int unsigned NPORTS = 4,
	parameter int unsigned ADDR_W = 13
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// framer side
	input wire logic [NPORTS-1:0] frame_tick,
	input wire logic [NPORTS-1:0] freeze_request,
	input wire logic [NPORTS-1:0] e1_mode,
	input wire logic [NPORTS-1:0] rai_raw,
	input wire logic [NPORTS-1:0][7:0] monitor_data,
	input rxf_port_cfg_t [NPORTS-1:0] port_cfg
);
	// =====================================================================
	// helpers
	logic wr_acc;
	assign wr_acc = psel && penable && pready && pwrite;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// =====================================================================
	// properties, port 0 watched in depth
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_read_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	a_refused_no_data: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("refused access carried data");
	a_reset_busy_set: assert property (wr_acc && paddr == 'h40 && pwdata[6]
		|=> port_cfg[0].hdlc_reset_busy) else $error("hdlc reset did not start");
	a_reset_busy_end: assert property ($fell(port_cfg[0].hdlc_reset_busy)
		|-> $past(frame_tick[0])) else $error("hdlc reset ended off a frame");
	a_channel_hold: assert property ($changed(port_cfg[0].channel_active)
		|-> $fell(port_cfg[0].hdlc_reset_busy)) else $error("channel moved without reset");
	a_t1_force_ones: assert property (wr_acc && paddr == 'h4C && !e1_mode[0]
		|=> port_cfg[0].force_sig_ones == $past(pwdata[4])) else $error("ones force wrong");
	a_alarm_direct: assert property (
		$past(presetn) && !port_cfg[0].remote_alarm_integrate[*2]
		|-> port_cfg[0].remote_alarm == $past(rai_raw[0])) else $error("alarm not one late");
endmodule // rxf_ctrl_regs_properties

// ### verif/tb.sv
`timescale 1ns/1ps
module tb import rxf_pkg::*;;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, re;
	logic [12:0] paddr;
	logic [31:0] pwdata, prdata, rv;
	logic [3:0] frame_tick, freeze_request, e1_mode, rai_raw;
	logic [3:0][7:0] monitor_data;
	rxf_port_cfg_t [3:0] port_cfg;
	int fail_count, n_compared;
	logic [8:0] ix[5] = '{IDX_HDLC_CONTROL, IDX_BIT_SUPPRESS, IDX_MONITOR_SELECT,
		IDX_SIG_CONTROL, IDX_T1_CONTROL_TWO};
	logic [7:0] mk[5] = '{8'hBF, 8'hFF, 8'h1F, 8'h17, 8'h1F};
	logic [2:0] oofx[4] = '{OOF_WIN_4, OOF_WIN_5, OOF_WIN_6, OOF_WIN_6};

	// short alarm count keeps the run small
	rxf_ctrl_regs #(.RAI_INTEG_CYCLES(8)) rxf_ctrl_regs_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .frame_tick(frame_tick),
		.freeze_request(freeze_request), .e1_mode(e1_mode), .rai_raw(rai_raw),
		.monitor_data(monitor_data), .port_cfg(port_cfg));

	// =====================================================================
	// bus and compare tasks
	task chk(string nm, logic [31:0] x, logic [31:0] g);
		n_compared++;
		if (g !== x) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, x, g);
		end
	endtask
	function logic [12:0] ad(int p, logic [8:0] i);
		return 13'((32'(i) + p * PORT_STRIDE_IDX) * 4);
	endfunction
	// idle cycle after each transfer so checks see committed state
	task apb(logic w, logic [12:0] a, logic [7:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		// look mid-cycle: pready and prdata are settled and hold until the next edge
		do begin
			@(negedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			fail_count++;
			$display("CHECK FAILED pready expected 1 seen %b", pready);
			test_done();
		end
		rv = prdata;
		re = pslverr;
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task rd(int p, logic [8:0] i, logic [7:0] x);
		apb(1'b0, ad(p, i), 8'h00);
		chk("rdata", {24'h0, x}, rv);
	endtask
	task tick();
		frame_tick[0] <= 1'b1;
		@(posedge pclk);
		frame_tick[0] <= 1'b0;
		@(posedge pclk);
	endtask

	// =====================================================================
	// scenarios
	task t_reset();
		for (int p = 0; p < 4; p++) for (int k = 0; k < 5; k++) rd(p, ix[k], 8'h00);
		chk("oof_window", OOF_WIN_4, port_cfg[0].oof_window);
		chk("stable", SIG_IMMEDIATE, port_cfg[0].sig_stable_multiframes);
	endtask
	task t_mask();
		for (int p = 0; p < 4; p++) for (int k = 0; k < 5; k++) begin
			apb(1'b1, ad(p, ix[k]), (k == 0) ? 8'hBF : 8'hFF);
			rd(p, ix[k], mk[k]);
		end
		chk("crc", 1, port_cfg[3].crc_display);
		chk("map", 1, port_cfg[3].map_select);
		chk("suppress", 8'hFF, port_cfg[3].bit_suppress);
		chk("monitor", 5'h1F, port_cfg[3].monitor_channel);
		chk("ones", 1, port_cfg[3].force_sig_ones);
		chk("stable", SIG_INTEG_MULTIFRAMES, port_cfg[3].sig_stable_multiframes);
		chk("slc", 1, port_cfg[3].subscriber_sync_enable);
		chk("d4", 1, port_cfg[3].superframe_alarm_select);
		chk("chan", 5'h00, port_cfg[3].channel_active);
		for (int p = 0; p < 4; p++) for (int k = 0; k < 5; k++) apb(1'b1, ad(p, ix[k]), 8'h00);
	endtask
	task t_oof();
		for (int v = 0; v < 4; v++) begin
			apb(1'b1, ad(0, IDX_T1_CONTROL_TWO), 8'(v << 2));
			chk("oof_window", oofx[v], port_cfg[0].oof_window);
		end
	endtask
	task t_hdlc();
		apb(1'b1, ad(0, IDX_HDLC_CONTROL), 8'h05);
		tick();
		tick();
		chk("chan", 5'h00, port_cfg[0].channel_active);
		apb(1'b1, ad(0, IDX_HDLC_CONTROL), 8'h45);
		rd(0, IDX_HDLC_CONTROL, 8'h45);
		tick();
		chk("busy", 1, port_cfg[0].hdlc_reset_busy);
		tick();
		chk("busy", 0, port_cfg[0].hdlc_reset_busy);
		chk("chan", 5'h05, port_cfg[0].channel_active);
		rd(0, IDX_HDLC_CONTROL, 8'h05);
	endtask
	task t_cas();
		e1_mode[1] <= 1'b1;
		apb(1'b1, ad(1, IDX_SIG_CONTROL), 8'h10);
		chk("cas", 1, port_cfg[1].cas_resync_mode);
		chk("ones", 0, port_cfg[1].force_sig_ones);
	endtask
	task t_freeze();
		apb(1'b1, ad(0, IDX_SIG_CONTROL), 8'h02);
		freeze_request[0] <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("freeze", 1, port_cfg[0].sig_freeze);
		apb(1'b1, ad(0, IDX_SIG_CONTROL), 8'h00);
		repeat (3) @(posedge pclk);
		chk("freeze", 0, port_cfg[0].sig_freeze);
		freeze_request[0] <= 1'b0;
		apb(1'b1, ad(0, IDX_SIG_CONTROL), 8'h04);
		repeat (3) @(posedge pclk);
		chk("freeze", 1, port_cfg[0].sig_freeze);
	endtask
	task t_rai();
		rai_raw[0] <= 1'b1;
		repeat (2) @(posedge pclk);
		chk("alarm", 1, port_cfg[0].remote_alarm);
		rai_raw[0] <= 1'b0;
		apb(1'b1, ad(0, IDX_T1_CONTROL_TWO), 8'h02);
		// integrated: flips only after nine differing cycles, checked on both sides
		rai_raw[0] <= 1'b1;
		repeat (8) @(posedge pclk);
		@(negedge pclk);
		chk("alarm", 0, port_cfg[0].remote_alarm);
		@(negedge pclk);
		chk("alarm", 1, port_cfg[0].remote_alarm);
		@(posedge pclk);
		rai_raw[0] <= 1'b0;
		repeat (8) @(posedge pclk);
		@(negedge pclk);
		chk("alarm", 1, port_cfg[0].remote_alarm);
		@(negedge pclk);
		chk("alarm", 0, port_cfg[0].remote_alarm);
		@(posedge pclk);
	endtask
	task t_bad();
		monitor_data[2] <= 8'hA5;
		rd(2, IDX_MONITOR_DATA, 8'hA5);
		apb(1'b1, ad(0, 9'h015), 8'hFF);
		chk("slverr", 1, re);
		apb(1'b0, 13'h1FFC, 8'h00);
		chk("slverr", 1, re);
	endtask
	task test_done();
		$display("compared %0d failed %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// =====================================================================
	// run
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	initial begin
		#200us;
		fail_count++;
		test_done();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{frame_tick, freeze_request, e1_mode, rai_raw, monitor_data} = '0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_mask();
		t_oof();
		t_hdlc();
		t_cas();
		t_freeze();
		t_rai();
		t_bad();
		test_done();
	end
endmodule // tb

bind rxf_ctrl_regs rxf_ctrl_regs_properties #(.NPORTS(NPORTS), .ADDR_W(ADDR_W)) props_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.frame_tick(frame_tick), .freeze_request(freeze_request), .e1_mode(e1_mode),
	.rai_raw(rai_raw), .monitor_data(monitor_data), .port_cfg(port_cfg));
